/* core/cvdc_top.sv */
// Capacitive divider sequencer and computation selector, AHB-Lite slave.
// Overview of operation
// - Precharge runs only when its duration setting is non-zero.
// - Go bit, trigger or computation restart each begin precharge.
// - A zero precharge duration skips the precharge phase.
// - Precharge ties the hold capacitor to supply or ground by polarity.
// - Precharge drives the pin to the level opposite the hold capacitor.
// - Precharge length equals the precharge duration setting.
// - Precharge pin drive overrides the pin tristate direction.
// - Acquisition starts at conversion start or at precharge end.
// - Acquisition returns the pin to its tristate direction and connects the channel.
// - With precharge, acquisition setting zero means 256 cycles.
// - Without precharge, acquisition setting zero disables timing.
// - Two guard outputs follow guard polarity and invert enable.
// - First precharge start drives both guards to guard polarity.
// - Acquisition start inverts guard A and keeps guard B.
// - Second precharge with invert sets both guards inverse; A toggles.
// - Extra capacitance is on while sampling, off during conversion.
// - Mode field selects basic, accumulate, average, burst or filter.
// - Basic mode converts one or two samples, done flag after the last.
// - Accumulate adds and counts every trigger, tests every trigger.
// - Average tests at repeat count, clears on the next trigger.
// - Burst clears at trigger, converts to repeat count, then tests.
// - Filter passes every result; tests each one after repeat count.
// - After acquisition the held voltage is converted.
// - Differential second sample inverts both precharge levels.
//
// Local design decisions: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
module cvdc_top #(
    parameter int ACC_W     = 24,
    parameter int LPF_SHIFT = 2
) (
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        special_trigger,
    input  wire logic        conv_done,
    input  wire logic [9:0]  conv_result,
    input  wire logic        pin_tristate_direction,
    output logic             conv_start,
    output logic             hold_tie,
    output logic             hold_level,
    output logic             pad_out,
    output logic             pad_oe_n,
    output logic             chan_connect,
    output logic [3:0]       extra_cap,
    output logic             guard_output_a,
    output logic             guard_output_b,
    output logic             busy
);
    import cvdc_pkg::*;

    function automatic logic signed [ACC_W-1:0] ext10(input logic [9:0] v);
        ext10 = {{(ACC_W-10){1'b0}}, v};
    endfunction : ext10

    cvdc_tmr_if tmr ();
    cvdc_phase_timer u_timer (.clock(clock), .reset(reset), .tmr(tmr));

    cvdc_state_t            state_q, state_d, first_ph;
    cvdc_mode_t             mode_q;
    logic                   go_q, dsen_q, ppol_q, gpol_q, ipen_q;
    logic [3:0]             cap_q;
    logic [7:0]             pre_q, acq_q, rpt_q, cnt_q, cnt_n, cnt_inc;
    logic signed [ACC_W-1:0] thr_q, acc_q, acc_n, val_q;
    logic [9:0]             s1_q;
    logic                   second_q, second_d, done_q, thr_hit_q;
    logic                   ap_wr_q, rd_pend_q, hready_q;
    logic [7:0]             ap_addr_q;
    logic [31:0]            rd_mux, hrdata_q;
    logic                   conv_start_q, hold_tie_q, hold_level_q;
    logic                   pad_out_q, pad_oe_n_q, chan_q, ga_q, gb_q;
    logic [3:0]             cap_out_q;
    logic                   test_c, busy_q;

    // Bus slave: writes complete with no wait, reads take one wait state
    // so that a read right after a write sees the new value.
    wire ap_ok   = hsel & htrans[1] & hready;
    wire wr_ctrl = ap_wr_q && ap_addr_q == OFS_CTRL;
    wire wr_pre  = ap_wr_q && ap_addr_q == OFS_PRE;
    wire wr_acq  = ap_wr_q && ap_addr_q == OFS_ACQ;
    wire wr_rpt  = ap_wr_q && ap_addr_q == OFS_RPT;
    wire wr_thr  = ap_wr_q && ap_addr_q == OFS_THR;
    wire wr_stat = ap_wr_q && ap_addr_q == OFS_STAT;

    always_ff @(posedge clock) begin
        if (reset) begin
            ap_wr_q   <= 1'b0;
            rd_pend_q <= 1'b0;
            ap_addr_q <= 8'h00;
            hready_q  <= 1'b1;
            hrdata_q  <= RD_ZERO;
        end else begin
            ap_wr_q   <= ap_ok & hwrite;
            rd_pend_q <= ap_ok & ~hwrite;
            hready_q  <= ~(ap_ok & ~hwrite);
            if (ap_ok) begin
                ap_addr_q <= haddr[7:0];
            end
            hrdata_q  <= rd_pend_q ? rd_mux : RD_ZERO;
        end
    end

    always_comb begin
        rd_mux = RD_ZERO;
        case (ap_addr_q)
            OFS_CTRL: rd_mux = {20'h0_0000, cap_q, ipen_q, gpol_q, ppol_q,
                                dsen_q, mode_q, go_q | busy};
            OFS_PRE:  rd_mux = {24'h00_0000, pre_q};
            OFS_ACQ:  rd_mux = {24'h00_0000, acq_q};
            OFS_RPT:  rd_mux = {24'h00_0000, rpt_q};
            OFS_THR:  rd_mux = {{(32-ACC_W){thr_q[ACC_W-1]}}, thr_q};
            OFS_STAT: rd_mux = {28'h000_0000, second_q, busy, thr_hit_q,
                                done_q};
            OFS_ACC:  rd_mux = {{(32-ACC_W){acc_q[ACC_W-1]}}, acc_q};
            OFS_CNT:  rd_mux = {24'h00_0000, cnt_q};
            default:  rd_mux = RD_ZERO;
        endcase
    end

    // Conversion start and phase selection.
    wire start_c = state_q == ST_IDLE && (go_q || special_trigger);
    wire dbl_c   = state_q == ST_CONV && conv_done && dsen_q && !second_q;
    wire restart_c = state_q == ST_CALC && mode_q == MD_BURST
                     && cnt_inc < rpt_q;
    assign first_ph = (pre_q != 8'h00) ? ST_PRE :
                      (acq_q != 8'h00) ? ST_ACQ :
                      ST_CONV;
    assign cnt_inc = (cnt_q == CNT_SAT) ? cnt_q : cnt_q + 8'h01;

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: if (start_c) state_d = first_ph;
            ST_PRE:  if (tmr.expired) state_d = ST_ACQ;
            ST_ACQ:  if (tmr.expired) state_d = ST_CONV;
            ST_CONV: begin
                if (conv_done) begin
                    state_d = dbl_c ? first_ph : ST_CALC;
                end
            end
            ST_CALC: state_d = restart_c ? first_ph : ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end

    assign second_d = dbl_c ? 1'b1 :
                      (start_c || state_q == ST_CALC) ? 1'b0 : second_q;

    wire enter_pre  = state_d == ST_PRE && state_q != ST_PRE;
    wire enter_acq  = state_d == ST_ACQ && state_q != ST_ACQ;
    wire enter_conv = state_d == ST_CONV
                      && (state_q != ST_CONV || conv_done);
    wire [TW-1:0] acq_len = (acq_q == 8'h00) ? ACQ_MAX
                            : {1'b0, acq_q};
    assign tmr.load  = enter_pre | enter_acq;
    assign tmr.value = enter_pre ? {1'b0, pre_q} : acq_len;
    wire hold_lvl_d  = ppol_q ^ second_d;
    wire sampling_d  = state_d == ST_IDLE || state_d == ST_ACQ;

    always_ff @(posedge clock) begin
        if (reset) begin
            state_q  <= ST_IDLE;
            second_q <= 1'b0;
            busy_q   <= 1'b0;
        end else begin
            state_q  <= state_d;
            second_q <= second_d;
            busy_q   <= state_d != ST_IDLE;
        end
    end

    // Analog switch and pin controls are registered from the next state,
    // so every control lines up with the phase it belongs to.
    always_ff @(posedge clock) begin
        if (reset) begin
            conv_start_q <= 1'b0;
            hold_tie_q   <= 1'b0;
            hold_level_q <= 1'b0;
            pad_out_q    <= 1'b0;
            pad_oe_n_q   <= 1'b1;
            chan_q       <= 1'b0;
            cap_out_q    <= 4'h0;
        end else begin
            conv_start_q <= enter_conv;
            hold_tie_q   <= state_d == ST_PRE;
            hold_level_q <= hold_lvl_d;
            pad_out_q    <= ~hold_lvl_d;
            pad_oe_n_q   <= (state_d == ST_PRE) ? 1'b0
                            : pin_tristate_direction;
            chan_q       <= sampling_d;
            cap_out_q    <= sampling_d ? cap_q : 4'h0;
        end
    end

    // Guard ring drive.
    always_ff @(posedge clock) begin
        if (reset) begin
            ga_q <= 1'b0;
            gb_q <= 1'b0;
        end else if (enter_pre) begin
            ga_q <= (second_d && ipen_q) ? ~gpol_q : gpol_q;
            gb_q <= (second_d && ipen_q) ? ~gpol_q : gpol_q;
        end else if (enter_acq) begin
            ga_q <= ~ga_q;
        end
    end

    // Per-mode computation, applied once in ST_CALC per measurement of one or two samples.
    always_comb begin
        acc_n  = acc_q;
        cnt_n  = cnt_q;
        test_c = 1'b0;
        case (mode_q)
            MD_ACCUM: begin
                acc_n  = acc_q + val_q;
                cnt_n  = cnt_inc;
                test_c = 1'b1;
            end
            MD_AVG, MD_BURST: begin
                acc_n  = acc_q + val_q;
                cnt_n  = cnt_inc;
                test_c = cnt_inc >= rpt_q;
            end
            MD_LPF: begin
                acc_n  = acc_q + val_q - (acc_q >>> LPF_SHIFT);
                cnt_n  = cnt_inc;
                test_c = cnt_inc >= rpt_q;
            end
            default: acc_n = acc_q;
        endcase
    end

    wire clr_acc = start_c && (mode_q == MD_BURST
                   || (mode_q == MD_AVG && cnt_q >= rpt_q));
    wire set_done = state_q == ST_CALC;
    wire set_thr  = set_done && test_c && acc_n > thr_q;

    always_ff @(posedge clock) begin
        if (reset) begin
            acc_q <= '0;
            cnt_q <= 8'h00;
            s1_q  <= 10'h000;
            val_q <= '0;
        end else begin
            if (clr_acc) begin
                acc_q <= '0;
                cnt_q <= 8'h00;
            end else if (set_done) begin
                acc_q <= acc_n;
                cnt_q <= cnt_n;
            end
            if (dbl_c) begin
                s1_q <= conv_result;
            end else if (state_q == ST_CONV && conv_done) begin
                val_q <= dsen_q ? ext10(conv_result) - ext10(s1_q)
                                : ext10(conv_result);
            end
        end
    end

    // Software registers; a hardware set wins over a same-cycle clear.
    always_ff @(posedge clock) begin
        if (reset) begin
            go_q      <= 1'b0;
            mode_q    <= MD_BASIC;
            dsen_q    <= 1'b0;
            ppol_q    <= 1'b0;
            gpol_q    <= 1'b0;
            ipen_q    <= 1'b0;
            cap_q     <= 4'h0;
            pre_q     <= 8'h00;
            acq_q     <= 8'h00;
            rpt_q     <= 8'h00;
            thr_q     <= '0;
            done_q    <= 1'b0;
            thr_hit_q <= 1'b0;
        end else begin
            go_q <= (go_q & ~start_c) | (wr_ctrl & hwdata[B_GO]);
            if (wr_ctrl) begin
                mode_q <= cvdc_mode_t'(hwdata[B_MODE+2:B_MODE]);
                dsen_q <= hwdata[B_DSEN];
                ppol_q <= hwdata[B_PPOL];
                gpol_q <= hwdata[B_GPOL];
                ipen_q <= hwdata[B_IPEN];
                cap_q  <= hwdata[B_CAP+3:B_CAP];
            end
            if (wr_pre) pre_q <= hwdata[7:0];
            if (wr_acq) acq_q <= hwdata[7:0];
            if (wr_rpt) rpt_q <= hwdata[7:0];
            if (wr_thr) thr_q <= hwdata[ACC_W-1:0];
            done_q <= set_done | (done_q & ~(wr_stat & hwdata[B_DONE]));
            thr_hit_q <= set_thr | (thr_hit_q & ~(wr_stat & hwdata[B_THR]));
        end
    end

    assign hreadyout      = hready_q;
    assign hresp          = 1'b0;
    assign hrdata         = hrdata_q;
    assign conv_start     = conv_start_q;
    assign hold_tie       = hold_tie_q;
    assign hold_level     = hold_level_q;
    assign pad_out        = pad_out_q;
    assign pad_oe_n       = pad_oe_n_q;
    assign chan_connect   = chan_q;
    assign extra_cap      = cap_out_q;
    assign guard_output_a = ga_q;
    assign guard_output_b = gb_q;
    assign busy           = busy_q;

    // Cycle count within the current phase, read only by the checks below.
    logic [8:0] ph_cyc_q;
    always_ff @(posedge clock) begin
        if (reset || state_d != state_q) ph_cyc_q <= 9'h000;
        else ph_cyc_q <= ph_cyc_q + 9'h001;
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    sequence s_pre_to_acq;
        (state_q == ST_PRE) ##1 (state_q == ST_ACQ);
    endsequence
    sequence s_first_pre;
        (state_q != ST_PRE) ##1 (state_q == ST_PRE && !second_q);
    endsequence

    pre_skip_a: assert property (
        start_c && pre_q == 8'h00 |=> state_q != ST_PRE)
        else $error("precharge ran with zero duration");
    pre_run_a: assert property (
        start_c && pre_q != 8'h00 |=> state_q == ST_PRE && hold_tie_q)
        else $error("precharge did not start");
    pre_len_a: assert property (
        state_q == ST_PRE && state_d != ST_PRE
        |-> ph_cyc_q == {1'b0, pre_q} - 9'h001)
        else $error("precharge length wrong");
    acq_max_a: assert property (
        state_q == ST_ACQ && state_d != ST_ACQ && acq_q == 8'h00
        |-> ph_cyc_q == 9'h0ff)
        else $error("acquisition not 256 cycles");
    pad_drive_a: assert property (
        state_q == ST_PRE |-> !pad_oe_n_q && pad_out_q != hold_level_q)
        else $error("pin not driven opposite hold level");
    acq_conn_a: assert property (
        state_q == ST_ACQ |-> chan_q && !hold_tie_q)
        else $error("channel not connected in acquisition");
    guard_flip_a: assert property (
        s_pre_to_acq |-> ga_q != $past(ga_q) && gb_q == $past(gb_q))
        else $error("guard outputs wrong at acquisition");
    guard_first_a: assert property (
        s_first_pre |-> ga_q == gpol_q && gb_q == gpol_q)
        else $error("guards not at polarity on first precharge");
    cap_off_a: assert property (
        state_q == ST_CONV |-> cap_out_q == 4'h0)
        else $error("extra capacitance on during conversion");
    done_set_a: assert property (
        state_q == ST_CALC |=> done_q ##1 (done_q || $past(wr_stat)))
        else $error("done flag not set after conversion");
endmodule : cvdc_top

/* core/cvdc_pkg.sv */
// Package of register map, field positions and types for the sequencer.
package cvdc_pkg;
    localparam logic [7:0] OFS_CTRL  = 8'h00;
    localparam logic [7:0] OFS_PRE   = 8'h04;
    localparam logic [7:0] OFS_ACQ   = 8'h08;
    localparam logic [7:0] OFS_RPT   = 8'h0c;
    localparam logic [7:0] OFS_THR   = 8'h10;
    localparam logic [7:0] OFS_STAT  = 8'h14;
    localparam logic [7:0] OFS_ACC   = 8'h18;
    localparam logic [7:0] OFS_CNT   = 8'h1c;

    localparam int B_GO    = 0;
    localparam int B_MODE  = 1;
    localparam int B_DSEN  = 4;
    localparam int B_PPOL  = 5;
    localparam int B_GPOL  = 6;
    localparam int B_IPEN  = 7;
    localparam int B_CAP   = 8;
    localparam int B_DONE  = 0;
    localparam int B_THR   = 1;
    localparam int B_BUSY  = 2;
    localparam int B_SEC   = 3;

    localparam int TW = 9;
    localparam logic [TW-1:0] ACQ_MAX = 9'h100;
    localparam logic [7:0]    CNT_SAT = 8'hff;
    localparam logic [31:0]   RD_ZERO = 32'h0000_0000;

    typedef enum logic [2:0] {
        MD_BASIC, MD_ACCUM, MD_AVG, MD_BURST, MD_LPF
    } cvdc_mode_t;

    typedef enum {ST_IDLE, ST_PRE, ST_ACQ, ST_CONV, ST_CALC} cvdc_state_t;
endpackage : cvdc_pkg

/* core/cvdc_tmr_if.sv */
// Interface between the sequencer and its phase timer.
`timescale 1ns/1ps
interface cvdc_tmr_if;
    import cvdc_pkg::*;
    logic          load;
    logic [TW-1:0] value;
    logic          expired;
    modport timer (input load, input value, output expired);
    modport user  (output load, output value, input expired);
endinterface : cvdc_tmr_if

/* core/cvdc_phase_timer.sv */
// Down-counter that times the precharge and acquisition phases.
`timescale 1ns/1ps
module cvdc_phase_timer (
    input wire logic    clock,
    input wire logic    reset,
    cvdc_tmr_if.timer   tmr
);
    import cvdc_pkg::*;
    logic [TW-1:0] cnt_q;

    // A load of N keeps the phase open for exactly N clock cycles.
    always_ff @(posedge clock) begin
        if (reset) begin
            cnt_q <= '0;
        end else if (tmr.load) begin
            cnt_q <= tmr.value;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    assign tmr.expired = (cnt_q == 9'h001);
endmodule : cvdc_phase_timer

/* sim/cvdc_sensor_model.sv */
// Behavioural touch sensor and converter facing the sequencer.
`timescale 1ns/1ps
module cvdc_sensor_model (
    input  wire logic       clock,
    input  wire logic       reset,
    input  wire logic       conv_start,
    input  wire logic       pad_out,
    input  wire logic       pad_oe_n,
    input  wire logic [9:0] res_hi,
    input  wire logic [9:0] res_lo,
    input  wire logic [1:0] lag,
    output logic            conv_done,
    output logic [9:0]      conv_result
);
    logic       node_q;
    logic       pend_q;
    logic [2:0] wait_q;

    always_ff @(posedge clock) begin
        if (reset) begin
            node_q      <= 1'b0;
            pend_q      <= 1'b0;
            wait_q      <= 3'h0;
            conv_done   <= 1'b0;
            conv_result <= 10'h000;
        end else begin
            conv_done   <= 1'b0;
            // Result lines churn outside the done pulse so no stale value
            // can pass for a fresh one.
            conv_result <= ~conv_result;
            if (!pad_oe_n) begin
                node_q <= pad_out;
            end
            if (conv_start) begin
                pend_q <= 1'b1;
                wait_q <= {1'b0, lag};
            end else if (pend_q && wait_q != 3'h0) begin
                wait_q <= wait_q - 3'h1;
            end else if (pend_q) begin
                pend_q      <= 1'b0;
                conv_done   <= 1'b1;
                conv_result <= node_q ? res_hi : res_lo;
            end
        end
    end
endmodule : cvdc_sensor_model

/* sim/tb_cvdc_top.sv */
// Self-checking testbench of the sequencer and computation selector.
`timescale 1ns/1ps
module tb_cvdc_top;
    import cvdc_pkg::*;
    localparam int LPF_SH = 2;
    logic        clock = 1'b0;
    logic        reset = 1'b1;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0]  htrans = 2'b00;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'b010;
    logic [31:0] hwdata = 32'h0000_0000;
    logic        special_trigger = 1'b0;
    logic        pin_tristate_direction = 1'b1;
    logic [9:0]  res_hi = 10'h155;
    logic [9:0]  res_lo = 10'h0aa;
    logic [1:0]  lag = 2'b00;
    logic        hready, hreadyout, hresp, conv_done, conv_start, busy;
    logic        hold_tie, hold_level, pad_out, pad_oe_n, chan_connect;
    logic        guard_output_a, guard_output_b;
    logic [31:0] hrdata, rd, st;
    logic [9:0]  conv_result;
    logic [3:0]  extra_cap;
    int          err_count = 0;
    int          checked = 0;
    int          cyc = 0;
    int          acc_e, cnt_e, thr;
    logic        ga_e, gb_e;
    integer      seed = 32'h9c0b;

    assign hready = hreadyout;
    always #50 clock = ~clock;

    cvdc_top #(.ACC_W(24), .LPF_SHIFT(LPF_SH)) u_cvdc_top (
        .clock(clock), .reset(reset), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .special_trigger(special_trigger),
        .conv_done(conv_done), .conv_result(conv_result),
        .pin_tristate_direction(pin_tristate_direction),
        .conv_start(conv_start), .hold_tie(hold_tie),
        .hold_level(hold_level), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
        .chan_connect(chan_connect), .extra_cap(extra_cap),
        .guard_output_a(guard_output_a), .guard_output_b(guard_output_b),
        .busy(busy));

    cvdc_sensor_model u_cvdc_sensor_model (
        .clock(clock), .reset(reset), .conv_start(conv_start),
        .pad_out(pad_out), .pad_oe_n(pad_oe_n), .res_hi(res_hi),
        .res_lo(res_lo), .lag(lag), .conv_done(conv_done),
        .conv_result(conv_result));

    task automatic test_done();
        $display("Checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] got, exp, input string what);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic do_reset();
        reset <= 1'b1;
        {ga_e, gb_e} = 2'b00;
        repeat (4) @(posedge clock);
        reset <= 1'b0;
    endtask : do_reset

    // Address phase is held until hready, then the data phase likewise.
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clock);
        hsel   <= 1'b1;
        haddr  <= {24'h00_0000, a};
        htrans <= 2'b10;
        hwrite <= wr;
        @(posedge clock);
        while (hreadyout !== 1'b1) @(posedge clock);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge clock);
        while (hreadyout !== 1'b1) @(posedge clock);
        rd = hrdata;
    endtask : bus

    function automatic logic [31:0] ctl(input logic [2:0] md,
        input logic ds, pp, gp, ip, input logic [3:0] cp, input logic go);
        return {20'h0_0000, cp, ip, gp, pp, ds, md, go};
    endfunction : ctl

    // Expected accumulator, count and threshold outcome of one trigger.
    function automatic logic step(input int m, r, rpt);
        if (m == MD_BURST || (m == MD_AVG && cnt_e >= rpt)) begin
            acc_e = 0;
            cnt_e = 0;
        end
        for (int i = 0; i < (m == MD_BURST ? rpt : 1); i++) begin
            if (m == MD_LPF) acc_e = r + acc_e - (acc_e >>> LPF_SH);
            else acc_e = acc_e + r;
            cnt_e++;
        end
        return (m == MD_ACCUM || cnt_e >= rpt) && acc_e > thr;
    endfunction : step

    task automatic run(input logic [7:0] pre, acq, input logic [2:0] md,
        input logic ds, pp, gp, ip, input logic [3:0] cp,
        input logic trig, input int reps);
        int   np, na, nc, n, k;
        logic sec, inacq, wasacq;
        np = 0;
        na = 0;
        nc = 0;
        k = 0;
        sec = 1'b0;
        wasacq = 1'b0;
        inacq = 1'b0;
        n = reps * (ds ? 2 : 1);
        lag <= 2'($random(seed));
        bus(1, OFS_PRE, {24'h00_0000, pre});
        bus(1, OFS_ACQ, {24'h00_0000, acq});
        bus(1, OFS_CTRL, ctl(md, ds, pp, gp, ip, cp, !trig));
        if (trig) begin
            special_trigger <= 1'b1;
            @(posedge clock);
            special_trigger <= 1'b0;
        end
        while (busy !== 1'b1 && k < 8) begin
            @(negedge clock);
            k++;
        end
        while (busy === 1'b1 && k < 4000) begin
            if (hold_tie === 1'b1) begin
                if (inacq && ds) sec = ~sec;
                inacq = 1'b0;
                wasacq = 1'b0;
                // Guards keep their level between runs unless precharge or acquisition start changes them.
                ga_e = gp ^ (sec & ip);
                gb_e = ga_e;
                np++;
                chk(pad_oe_n, 0, "pin drive");
                chk(pad_out, !(pp ^ sec), "pin level");
                chk(hold_level, pp ^ sec, "hold level");
                chk({guard_output_a, guard_output_b}, {ga_e, gb_e},
                    "gpre");
            end else if (chan_connect === 1'b1) begin
                if (!wasacq) ga_e = ~ga_e;
                inacq = 1'b1;
                wasacq = 1'b1;
                na++;
                chk({pad_oe_n, guard_output_a, guard_output_b},
                    {1'b1, ga_e, gb_e}, "acq pins");
                chk(extra_cap, cp, "cap acq");
            end else begin
                wasacq = 1'b0;
                chk(extra_cap, 0, "cap conv");
            end
            if (conv_start === 1'b1) nc++;
            @(negedge clock);
            k++;
        end
        chk(busy, 0, "finish");
        chk(np, pre * n, "pre len");
        chk(na, (acq != 0 ? acq : (pre != 0 ? 256 : 0)) * n,
            "acq len");
        chk(nc, n, "conversions");
        bus(0, OFS_STAT, 0);
        st = rd;
        chk(rd[B_DONE], 1, "done");
        bus(1, OFS_STAT, 32'h0000_0003);
    endtask : run

    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            test_done();
        end
    end

    initial begin
        int          r;
        logic        f;
        logic [31:0] a;
        do_reset();
        @(negedge clock);
        chk({hreadyout, hresp, pad_oe_n, busy, guard_output_a,
             guard_output_b, hold_tie}, 7'b1010000, "reset");
        @(posedge clock);
        pin_tristate_direction <= 1'b0;
        repeat (2) @(negedge clock);
        chk(pad_oe_n, 0, "idle dir");
        @(posedge clock);
        pin_tristate_direction <= 1'b1;
        bus(1, 8'h20, 32'hdead_beef);
        bus(0, 8'h20, 0);
        chk(rd, 0, "unmapped");
        run(2, 3, 3'h0, 0, 0, 1, 0, 4'h5, 0, 1);
        run(0, 0, 3'h0, 0, 1, 0, 0, 4'h2, 0, 1);
        run(0, 2, 3'h0, 0, 0, 0, 0, 4'h1, 1, 1);
        run(1, 0, 3'h0, 0, 0, 1, 0, 4'hf, 0, 1);
        run(3, 2, 3'h0, 1, 1, 0, 1, 4'h9, 1, 1);
        run(2, 1, 3'h0, 1, 0, 1, 0, 4'h4, 0, 1);
        repeat (4) begin
            a = $random(seed);
            run({6'h00, a[1:0]} + 8'h01, {5'h00, a[4:2]} + 8'h01, 3'h0,
                a[5], a[6], a[7], a[8], a[12:9], a[13], 1);
        end
        for (int m = 1; m < 5; m++) begin
            do_reset();
            acc_e = 0;
            cnt_e = 0;
            thr = $random(seed) & 32'h0000_03ff;
            bus(1, OFS_RPT, 32'h0000_0002);
            bus(1, OFS_THR, thr);
            for (int t = 0; t < 4; t++) begin
                r = ($random(seed) & 32'h0000_03ff) | 32'h0000_0001;
                res_hi <= r[9:0];
                run(1, 1, m[2:0], 0, 0, 0, 0, 4'h3, t[0], m == 3 ? 2 : 1);
                f = step(m, r, 2);
                chk(st[B_THR], f, "threshold");
                bus(0, OFS_ACC, 0);
                chk(rd, acc_e, "accumulator");
                bus(0, OFS_CNT, 0);
                chk(rd, cnt_e, "count");
            end
        end
        test_done();
    end
endmodule : tb_cvdc_top
